/* File: core/cwpd_regs.svh */
// Register offsets, field positions, reset values and timing counts of the clock controller.
`ifndef CWPD_REGS_SVH
`define CWPD_REGS_SVH

// ********************************************************************
// Register offsets
// ********************************************************************
`define CWPD_ADDR_FREQ     8'h00
`define CWPD_ADDR_SPREAD   8'h01
`define CWPD_ADDR_WDOG     8'h02
`define CWPD_ADDR_DIV_N    8'h07
`define CWPD_ADDR_DIV_R    8'h09
`define CWPD_ADDR_STATUS   8'h0a

// ********************************************************************
// Field positions
// ********************************************************************
`define CWPD_SPREAD_EN_BIT   7
`define CWPD_SPREAD_TYPE_BIT 6
`define CWPD_SPREAD_HI_BIT   1
`define CWPD_SPREAD_LO_BIT   0
`define CWPD_WD_STAT_BIT     7
`define CWPD_DIV_SRC_BIT     0
`define CWPD_ST_DOWN_BIT     0
`define CWPD_ST_FAMILY_BIT   1
`define CWPD_ST_TPG_BIT      2
`define CWPD_ST_WDRUN_BIT    3

// ********************************************************************
// Reset values
// ********************************************************************
`define CWPD_RST_FREQ    4'h0
`define CWPD_RST_SPREAD  4'h0
`define CWPD_RST_WDSEL   4'h0
`define CWPD_RST_DIV_N   7'h00
`define CWPD_RST_DIV_R   6'h00
// Pin lanes reset to their idle levels: power-good and power-down high.
// A zero here would hide the first power-good fall that follows reset.
`define CWPD_SYNC_IDLE   9'h140

// ********************************************************************
// Pin synchroniser lanes and clock channels
// ********************************************************************
`define CWPD_NSYNC      9
`define CWPD_NCHAN      6
`define CWPD_CH_REF     4
`define CWPD_CH_CPU     5
`define CWPD_SY_PD      6
`define CWPD_SY_FAM     7
`define CWPD_SY_TPG     8

// ********************************************************************
// Timing
// ********************************************************************
`define CWPD_CLK_MHZ        100
`define CWPD_RELOCK_US      1000
`define CWPD_REF_HZ         14318180
`define CWPD_SRST_REF_EDGES 16'h0598
`define CWPD_PD_SAMPLES     2'h2

`endif

/* File: core/cwpd_pkg.sv */
// Types shared by the clock controller modules.
package cwpd_pkg;
  // Power state of the clock outputs, one-hot.
  typedef enum logic [3:0] {
    CWPD_RUN    = 4'h1,
    CWPD_STOP   = 4'h2,
    CWPD_DOWN   = 4'h4,
    CWPD_RELOCK = 4'h8
  } cwpd_state_t;
endpackage

/* File: core/cwpd_wd_if.sv */
// Signals shared between the controller, the seconds tick and the watchdog.
`timescale 1ns/10ps
`default_nettype none
interface cwpd_wd_if;
  logic       ref_rise;   // One-cycle pulse on each reference rising edge.
  logic       sec_tick;   // One-cycle pulse once per second.
  logic       start;      // One-cycle pulse that starts the countdown.
  logic [3:0] sel;        // Timeout selection in seconds, zero is off.
  logic       expire;     // One-cycle pulse when the countdown runs out.
  logic       running;    // Countdown is active.
  logic       reset_act;  // System reset pulse is being driven.

  modport ctrl (output ref_rise, output start, output sel,
                input expire, input running, input reset_act);
  modport tick (input ref_rise, input start, output sec_tick);
  modport wdog (input ref_rise, input sec_tick, input start, input sel,
                output expire, output running, output reset_act);
endinterface
`default_nettype wire

/* File: core/cwpd_tick.sv */
// Seconds tick derived from the crystal reference edges.
`timescale 1ns/10ps
`default_nettype none
`include "cwpd_regs.svh"
module cwpd_tick #(
  parameter int unsigned REF_PER_SEC = `CWPD_REF_HZ
) (
  input wire logic CLK,
  input wire logic RST_N,
  cwpd_wd_if.tick  wd
);
  logic [23:0] cnt_r;  // Reference edges seen in the current second.

  // A start restarts the second so the first tick is a whole second away.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_r       <= 24'h000000;
      wd.sec_tick <= 1'b0;
    end else begin
      wd.sec_tick <= 1'b0;
      if (wd.start) begin
        cnt_r <= 24'h000000;
      end else if (wd.ref_rise) begin
        if (cnt_r == 24'(REF_PER_SEC - 1)) begin
          cnt_r       <= 24'h000000;
          wd.sec_tick <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 24'h000001;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: core/cwpd_wdog.sv */
// Watchdog countdown and system reset pulse.
`timescale 1ns/10ps
`default_nettype none
`include "cwpd_regs.svh"
module cwpd_wdog (
  input wire logic CLK,
  input wire logic RST_N,
  cwpd_wd_if.wdog  wd
);
  logic [3:0]  left_r;  // Seconds still to run.
  logic [15:0] rst_r;   // Reference edges left in the reset pulse.

  // Countdown: a zero selection stops it at once, without a reset.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      left_r     <= 4'h0;
      wd.running <= 1'b0;
      wd.expire  <= 1'b0;
    end else begin
      wd.expire <= 1'b0;
      if (wd.sel == 4'h0) begin
        wd.running <= 1'b0;
      end else if (wd.start) begin
        left_r     <= wd.sel;
        wd.running <= 1'b1;
      end else if (wd.running && wd.sec_tick) begin
        if (left_r == 4'h1) begin
          wd.running <= 1'b0;
          wd.expire  <= 1'b1;
        end
        left_r <= left_r - 4'h1;
      end
    end
  end

  // Reset pulse width counted in reference edges.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_r        <= 16'h0000;
      wd.reset_act <= 1'b0;
    end else if (wd.expire) begin
      rst_r        <= `CWPD_SRST_REF_EDGES;
      wd.reset_act <= 1'b1;
    end else if (wd.reset_act && wd.ref_rise) begin
      rst_r <= rst_r - 16'h0001;
      if (rst_r == 16'h0001) begin
        wd.reset_act <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: core/cwpd_ctrl.sv */
// Clock controller top: registers, spread select, watchdog sequencing and power-down gating.
// ********************************************************************
// ********************************************************************
`timescale 1ns/10ps
`default_nettype none
`include "cwpd_regs.svh"
module cwpd_ctrl #(
  parameter int unsigned WD_TICK_REF = `CWPD_REF_HZ,
  parameter int unsigned RELOCK_CYC  = `CWPD_RELOCK_US * `CWPD_CLK_MHZ
) (
  input  wire logic       CLK,
  input  wire logic       RST_N,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       CPU_CLK_IN,
  input  wire logic       REF_CLK_IN,
  input  wire logic [3:0] AUX_CLK_IN,
  input  wire logic       POWER_DOWN_IN_N,
  input  wire logic       CPU_FAMILY_SELECT,
  input  wire logic       TERM_POWER_GOOD_N,
  output logic      [3:0] AUX_CLK_OUT,
  output logic            REF_CLK_OUT,
  output logic            CPU_T_OUT,
  output logic            CPU_T_OE,
  output logic            CPU_T_BOOST,
  output logic            CPU_C_OUT,
  output logic            CPU_C_OE,
  output logic            SYS_RESET_OUT_N,
  output logic            PLL_EN,
  output logic            XTAL_EN,
  output logic            SPREAD_EN,
  output logic      [2:0] SPREAD_CODE,
  output logic      [3:0] SOFTWARE_FREQ_SELECT,
  output logic      [6:0] DIV_N,
  output logic      [5:0] DIV_R,
  output logic            DIVIDER_SOURCE_SEL
);

  // ********************************************************************
  // Pin synchronisers and edge detection
  // ********************************************************************
  logic [`CWPD_NSYNC-1:0] pins;      // Raw pin lanes.
  logic [`CWPD_NSYNC-1:0] sync1_r;   // First stage, read only by the second.
  logic [`CWPD_NSYNC-1:0] sync2_r;   // Safe copies of the pins.
  logic [`CWPD_NSYNC-1:0] sync3_r;   // One cycle older, for edge detection.
  logic [`CWPD_NCHAN-1:0] ch_rise;   // Rising edge per clock channel.
  logic [`CWPD_NCHAN-1:0] ch_fall;   // Falling edge per clock channel.

  assign pins = {TERM_POWER_GOOD_N, CPU_FAMILY_SELECT, POWER_DOWN_IN_N,
                 CPU_CLK_IN, REF_CLK_IN, AUX_CLK_IN};

  // Every pin comes from outside this clock, so it passes two flops first.
  // Reset loads the idle pin levels, so no edge is invented or lost.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_r <= `CWPD_SYNC_IDLE;
      sync2_r <= `CWPD_SYNC_IDLE;
      sync3_r <= `CWPD_SYNC_IDLE;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  assign ch_rise = sync2_r[`CWPD_NCHAN-1:0] & ~sync3_r[`CWPD_NCHAN-1:0];
  assign ch_fall = ~sync2_r[`CWPD_NCHAN-1:0] & sync3_r[`CWPD_NCHAN-1:0];

  // Family select: low picks open-drain, high picks differential.
  logic diff_mode;  // Differential processor outputs.
  assign diff_mode = sync2_r[`CWPD_SY_FAM];

  // ********************************************************************
  // Termination power-good, first fall only
  // ********************************************************************
  logic tpg_seen_r;  // Set by the first fall and never cleared again.

  // Later transitions are ignored, so the outputs cannot be stopped by it.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tpg_seen_r <= 1'b0;
    end else if (!sync2_r[`CWPD_SY_TPG] && sync3_r[`CWPD_SY_TPG]) begin
      tpg_seen_r <= 1'b1;
    end
  end

  // ********************************************************************
  // Power state machine
  // ********************************************************************
  cwpd_pkg::cwpd_state_t state_r;    // Current power state.
  cwpd_pkg::cwpd_state_t state_nxt;  // Next power state.
  logic [1:0]  pd_cnt_r;             // Consecutive low samples of power-down.
  logic        pd_edge;              // Processor clock edge that samples the pin.
  logic [19:0] relock_r;             // Cycles left before clocks are released.
  logic [`CWPD_NCHAN-1:0] stop_r;    // Channel held low.
  logic        all_stopped;          // Every channel has parked.

  // Differential mode samples on the complement's rising edge, which is
  // the true clock's falling edge; open-drain uses the true rising edge.
  assign pd_edge = diff_mode ? ch_fall[`CWPD_CH_CPU] : ch_rise[`CWPD_CH_CPU];
  assign all_stopped = &stop_r;

  // Count low samples; a single high sample starts the count over.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pd_cnt_r <= 2'h0;
    end else if (state_r != cwpd_pkg::CWPD_RUN) begin
      pd_cnt_r <= 2'h0;
    end else if (pd_edge) begin
      if (sync2_r[`CWPD_SY_PD]) begin
        pd_cnt_r <= 2'h0;
      end else if (pd_cnt_r != `CWPD_PD_SAMPLES) begin
        pd_cnt_r <= pd_cnt_r + 2'h1;
      end
    end
  end

  // Next state. Parking can take several reference periods, so the
  // machine waits for every channel instead of a fixed time.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      cwpd_pkg::CWPD_RUN: begin
        if (pd_cnt_r == `CWPD_PD_SAMPLES) begin
          state_nxt = cwpd_pkg::CWPD_STOP;
        end
      end
      cwpd_pkg::CWPD_STOP: begin
        if (sync2_r[`CWPD_SY_PD]) begin
          state_nxt = cwpd_pkg::CWPD_RELOCK;
        end else if (all_stopped) begin
          state_nxt = cwpd_pkg::CWPD_DOWN;
        end
      end
      cwpd_pkg::CWPD_DOWN: begin
        if (sync2_r[`CWPD_SY_PD]) begin
          state_nxt = cwpd_pkg::CWPD_RELOCK;
        end
      end
      cwpd_pkg::CWPD_RELOCK: begin
        if (relock_r == 20'h00000) begin
          state_nxt = cwpd_pkg::CWPD_RUN;
        end
      end
      default: begin
        state_nxt = cwpd_pkg::CWPD_RUN;
      end
    endcase
  end

  // State register.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= cwpd_pkg::CWPD_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Lock wait after wake-up; well inside the allowed wake-up latency.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      relock_r <= 20'h00000;
    end else if (state_nxt == cwpd_pkg::CWPD_RELOCK &&
                 state_r != cwpd_pkg::CWPD_RELOCK) begin
      relock_r <= 20'(RELOCK_CYC);
    end else if (relock_r != 20'h00000) begin
      relock_r <= relock_r - 20'h00001;
    end
  end

  // Synthesizer loops and oscillator are off only in the down state.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PLL_EN  <= 1'b1;
      XTAL_EN <= 1'b1;
    end else begin
      PLL_EN  <= (state_nxt != cwpd_pkg::CWPD_DOWN);
      XTAL_EN <= (state_nxt != cwpd_pkg::CWPD_DOWN);
    end
  end

  // ********************************************************************
  // Output gating per clock channel
  // ********************************************************************
  logic                   run_ok;   // Clocks may run.
  logic [`CWPD_NCHAN-1:0] gated_r;  // Gated copy of each channel.

  assign run_ok = (state_r == cwpd_pkg::CWPD_RUN) && tpg_seen_r;

  // A channel parks on its own falling edge, so no high pulse is cut
  // short, and restarts only on a rising edge, so no partial period.
  generate
    for (genvar i = 0; i < `CWPD_NCHAN; i++) begin : g_chan
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          stop_r[i]  <= 1'b1;
          gated_r[i] <= 1'b0;
        end else if (!run_ok) begin
          if (ch_fall[i] || !sync2_r[i]) begin
            stop_r[i] <= 1'b1;
          end
          gated_r[i] <= sync2_r[i] & ~stop_r[i] & ~ch_fall[i];
        end else begin
          if (ch_rise[i]) begin
            stop_r[i] <= 1'b0;
          end
          gated_r[i] <= sync2_r[i] & (~stop_r[i] | ch_rise[i]);
        end
      end
    end
  endgenerate

  assign AUX_CLK_OUT = gated_r[`CWPD_CH_REF-1:0];
  assign REF_CLK_OUT = gated_r[`CWPD_CH_REF];

  // Processor pins. Differential park holds true high at double current
  // with the complement released; open-drain park pulls both low.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      CPU_T_OUT   <= 1'b0;
      CPU_T_OE    <= 1'b0;
      CPU_T_BOOST <= 1'b0;
      CPU_C_OUT   <= 1'b0;
      CPU_C_OE    <= 1'b0;
    end else if (diff_mode) begin
      CPU_T_OUT   <= stop_r[`CWPD_CH_CPU] | gated_r[`CWPD_CH_CPU];
      CPU_T_OE    <= 1'b1;
      CPU_T_BOOST <= stop_r[`CWPD_CH_CPU];
      CPU_C_OUT   <= ~gated_r[`CWPD_CH_CPU];
      CPU_C_OE    <= ~stop_r[`CWPD_CH_CPU];
    end else begin
      CPU_T_OUT   <= 1'b0;
      CPU_T_OE    <= ~gated_r[`CWPD_CH_CPU];
      CPU_T_BOOST <= 1'b0;
      CPU_C_OUT   <= 1'b0;
      CPU_C_OE    <= gated_r[`CWPD_CH_CPU] | stop_r[`CWPD_CH_CPU];
    end
  end

  // ********************************************************************
  // Register file
  // ********************************************************************
  logic       bus_on;      // Management bus answers.
  logic       wr_en;       // Accepted write.
  logic       wd_stat_r;   // Watchdog timeout status.
  logic       spread_type_r; // Centre spread when set, down spread when clear.
  logic [1:0] spread_sel_r;  // Amount select, high and low bits.
  logic       freq_trig;   // Accepted write that changes the frequency.
  logic       wd_start_r;  // Countdown start, one cycle after the change.
  logic [7:0] rd_mux;      // Read data before the output flop.

  cwpd_wd_if wd ();

  // While shut down the bus is dead: writes are dropped, reads give zero.
  assign bus_on = (state_r != cwpd_pkg::CWPD_DOWN);
  assign wr_en  = WR & bus_on;

  // Frequency control writes; values take effect on the write edge.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SOFTWARE_FREQ_SELECT <= `CWPD_RST_FREQ;
      DIV_N                <= `CWPD_RST_DIV_N;
      DIV_R                <= `CWPD_RST_DIV_R;
      DIVIDER_SOURCE_SEL   <= 1'b0;
    end else if (wr_en) begin
      if (ADDR == `CWPD_ADDR_FREQ) begin
        SOFTWARE_FREQ_SELECT <= WDATA[3:0];
      end
      if (ADDR == `CWPD_ADDR_DIV_N) begin
        DIV_N <= WDATA[6:0];
      end
      if (ADDR == `CWPD_ADDR_DIV_R) begin
        DIV_R              <= WDATA[6:1];
        DIVIDER_SOURCE_SEL <= WDATA[`CWPD_DIV_SRC_BIT];
      end
    end
  end

  // Spread settings drive the modulator directly.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SPREAD_EN     <= 1'b0;
      spread_type_r <= 1'b0;
      spread_sel_r  <= 2'h0;
    end else if (wr_en && ADDR == `CWPD_ADDR_SPREAD) begin
      SPREAD_EN     <= WDATA[`CWPD_SPREAD_EN_BIT];
      spread_type_r <= WDATA[`CWPD_SPREAD_TYPE_BIT];
      spread_sel_r  <= {WDATA[`CWPD_SPREAD_HI_BIT], WDATA[`CWPD_SPREAD_LO_BIT]};
    end
  end

  // Code {type, hi, lo}: type 0 gives down 1.5/1.0/0.7/0.5 percent,
  // type 1 gives centre 0.75/0.5/0.35/0.25 percent.
  assign SPREAD_CODE = {spread_type_r, spread_sel_r};

  // Watchdog selection and its sticky status; a set beats a clear.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wd.sel    <= `CWPD_RST_WDSEL;
      wd_stat_r <= 1'b0;
    end else begin
      if (wr_en && ADDR == `CWPD_ADDR_WDOG) begin
        wd.sel <= WDATA[3:0];
      end
      if (wd.expire) begin
        wd_stat_r <= 1'b1;
      end else if (wr_en && ADDR == `CWPD_ADDR_WDOG && WDATA[`CWPD_WD_STAT_BIT]) begin
        wd_stat_r <= 1'b0;
      end
    end
  end

  // A new select value, or a new divider value while the registers are
  // the divider source, counts as a frequency change.
  always_comb begin
    freq_trig = 1'b0;
    if (wr_en) begin
      if (ADDR == `CWPD_ADDR_FREQ && WDATA[3:0] != SOFTWARE_FREQ_SELECT) begin
        freq_trig = 1'b1;
      end
      if (ADDR == `CWPD_ADDR_DIV_N && DIVIDER_SOURCE_SEL && WDATA[6:0] != DIV_N) begin
        freq_trig = 1'b1;
      end
      if (ADDR == `CWPD_ADDR_DIV_R && WDATA[`CWPD_DIV_SRC_BIT] &&
          WDATA[6:0] != {DIV_R, DIVIDER_SOURCE_SEL}) begin
        freq_trig = 1'b1;
      end
    end
  end

  // The start rises at the same edge that applies the value; without an armed
  // selection the change gets no recovery at all.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wd_start_r <= 1'b0;
    end else begin
      wd_start_r <= freq_trig && (wd.sel != 4'h0);
    end
  end

  assign wd.start    = wd_start_r;
  assign wd.ref_rise = ch_rise[`CWPD_CH_REF];

  // Read mux; unmapped offsets read zero.
  always_comb begin
    case (ADDR)
      `CWPD_ADDR_FREQ:   rd_mux = {4'h0, SOFTWARE_FREQ_SELECT};
      `CWPD_ADDR_SPREAD: rd_mux = {SPREAD_EN, spread_type_r, 4'h0, spread_sel_r};
      `CWPD_ADDR_WDOG:   rd_mux = {wd_stat_r, 3'h0, wd.sel};
      `CWPD_ADDR_DIV_N:  rd_mux = {1'b0, DIV_N};
      `CWPD_ADDR_DIV_R:  rd_mux = {1'b0, DIV_R, DIVIDER_SOURCE_SEL};
      `CWPD_ADDR_STATUS: rd_mux = {4'h0, wd.running, tpg_seen_r, diff_mode,
                                   state_r == cwpd_pkg::CWPD_DOWN};
      default:           rd_mux = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
    end else if (RD && bus_on) begin
      RDATA <= rd_mux;
    end else begin
      RDATA <= 8'h00;
    end
  end

  // ********************************************************************
  // Watchdog and system reset
  // ********************************************************************
  cwpd_tick #(
    .REF_PER_SEC (WD_TICK_REF)
  ) u_tick (
    .CLK   (CLK),
    .RST_N (RST_N),
    .wd    (wd.tick)
  );

  cwpd_wdog u_wdog (
    .CLK   (CLK),
    .RST_N (RST_N),
    .wd    (wd.wdog)
  );

  // Reset output low while the pulse counter runs.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SYS_RESET_OUT_N <= 1'b1;
    end else begin
      SYS_RESET_OUT_N <= ~wd.reset_act;
    end
  end

endmodule
`default_nettype wire

/* File: bench/cwpd_ctrl_asserts.sv */
// Port assertions for the clock controller.
`timescale 1ns/10ps
`default_nettype none
module cwpd_ctrl_asserts (
  input wire logic       CLK,
  input wire logic       RST_N,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic       PLL_EN,
  input wire logic       XTAL_EN,
  input wire logic       SPREAD_EN,
  input wire logic       SYS_RESET_OUT_N,
  input wire logic       CPU_FAMILY_SELECT,
  input wire logic       CPU_T_OUT,
  input wire logic       CPU_T_OE,
  input wire logic       CPU_T_BOOST,
  input wire logic       CPU_C_OE,
  input wire logic       REF_CLK_OUT,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic [7:0] RDATA,
  input wire logic [3:0] AUX_CLK_OUT,
  input wire logic [3:0] SOFTWARE_FREQ_SELECT,
  input wire logic [2:0] SPREAD_CODE
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  // Writes land at the strobe edge; a low enable marks the shut-down state.
  property p_sp_en; WR && ADDR == 8'h01 && PLL_EN |=> SPREAD_EN == $past(WDATA[7]); endproperty
  a_sp_en: assert property (p_sp_en) else $error("spread enable");
  property p_sp_code;
    WR && ADDR == 8'h01 && PLL_EN |=> SPREAD_CODE == {$past(WDATA[6]), $past(WDATA[1:0])};
  endproperty
  a_sp_code: assert property (p_sp_code) else $error("spread code");
  property p_dn_rd; RD && !PLL_EN |=> RDATA == 8'h00; endproperty
  a_dn_rd: assert property (p_dn_rd) else $error("read while down");
  property p_dn_wr; WR && !PLL_EN |=> $stable(SOFTWARE_FREQ_SELECT); endproperty
  a_dn_wr: assert property (p_dn_wr) else $error("write while down");
  property p_down; !PLL_EN |-> !XTAL_EN && AUX_CLK_OUT == 4'h0 && !REF_CLK_OUT; endproperty
  a_down: assert property (p_down) else $error("down outputs");
  property p_dpark;
    !PLL_EN && CPU_FAMILY_SELECT |-> CPU_T_OUT && CPU_T_OE && CPU_T_BOOST && !CPU_C_OE;
  endproperty
  a_dpark: assert property (p_dpark) else $error("differential park");
  property p_opark; !PLL_EN && !CPU_FAMILY_SELECT |-> CPU_T_OE && CPU_C_OE && !CPU_T_OUT; endproperty
  a_opark: assert property (p_opark) else $error("open-drain park");
  property p_srst; $fell(SYS_RESET_OUT_N) |-> !SYS_RESET_OUT_N [*8]; endproperty
  a_srst: assert property (p_srst) else $error("reset pulse short");
  c_down: cover property (!PLL_EN);
  c_srst: cover property ($fell(SYS_RESET_OUT_N));
  c_spread: cover property (WR && ADDR == 8'h01);
endmodule
`default_nettype wire

/* File: bench/cwpd_partner.sv */
// Clock sources beside the controller: processor and crystal reference.
`timescale 1ns/10ps
`default_nettype none
module cwpd_partner (
  input  wire logic pll_en,
  input  wire logic xtal_en,
  output logic      cpu_clk,
  output logic      ref_clk
);
  // Each clock halts low once its loop or the oscillator is switched off.
  initial begin
    cpu_clk = 1'b0;
    forever #40 cpu_clk = pll_en & ~cpu_clk;
  end
  initial begin
    ref_clk = 1'b0;
    forever #80 ref_clk = xtal_en & ~ref_clk;
  end
endmodule
`default_nettype wire

/* File: bench/cwpd_ctrl_tb.sv */
// Self-checking bench for the clock controller.
`timescale 1ns/10ps
`default_nettype none
module cwpd_ctrl_tb;
  logic       clk, rst_n, wr, rd, pd_n, fam, tpg_n, cpu, rc, ro, t_o, toe, bst, c_o, coe;
  logic       sr_n, pll, xen, spe, dsrc;
  logic [7:0] addr, wdata, rdata;
  logic [3:0] ao, software_freq_select;
  logic [2:0] spc, c;
  logic [6:0] dn;
  logic [5:0] dr;
  int         err_count, num_checks, cyc, n;
  cwpd_ctrl #(.WD_TICK_REF(20), .RELOCK_CYC(50)) cwpd_ctrl_i (.CLK(clk), .RST_N(rst_n),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .CPU_CLK_IN(cpu),
    .REF_CLK_IN(rc), .AUX_CLK_IN({cpu, rc, cpu, rc}), .POWER_DOWN_IN_N(pd_n),
    .CPU_FAMILY_SELECT(fam), .TERM_POWER_GOOD_N(tpg_n), .AUX_CLK_OUT(ao), .REF_CLK_OUT(ro),
    .CPU_T_OUT(t_o), .CPU_T_OE(toe), .CPU_T_BOOST(bst), .CPU_C_OUT(c_o), .CPU_C_OE(coe),
    .SYS_RESET_OUT_N(sr_n), .PLL_EN(pll), .XTAL_EN(xen), .SPREAD_EN(spe), .SPREAD_CODE(spc),
    .SOFTWARE_FREQ_SELECT(software_freq_select), .DIV_N(dn), .DIV_R(dr), .DIVIDER_SOURCE_SEL(dsrc));
  cwpd_partner cwpd_partner_i (.pll_en(pll), .xtal_en(xen), .cpu_clk(cpu), .ref_clk(rc));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", s, exp, seen);
    end
  endtask
  // Bus cycles: one-cycle strobes, read data taken in the cycle after.
  task automatic wrt(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", rdata, e);
  endtask
  // Bounded wait on the reset output or the loop enable; n holds the cycles spent.
  task automatic wt(input bit s, input logic v);
    n = 0;
    while ((s ? sr_n : pll) !== v && n < 30000) begin
      @(posedge clk);
      n++;
    end
    #1;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    {rst_n, wr, rd, addr, wdata, fam, pd_n, tpg_n} = 22'h7;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    tpg_n <= 1'b0;
    repeat (20) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      wrt(8'h01, {1'b1, c[2], 4'h0, c[1:0]});
      chk("sp_code", 8'(spc), 8'(c));
      chk("sp_en", 8'(spe), 8'h01);
    end
    wrt(8'h01, 8'h00);
    chk("sp_en", 8'(spe), 8'h00);
    wrt(8'h07, 8'h55);
    wrt(8'h09, 8'h0b);
    chk("div_src", 8'(dsrc), 8'h01);
    chk("div_n", 8'(dn), 8'h55);
    chk("div_r", 8'(dr), 8'h05);
    rdc(8'h0a, 8'h06);
    $display("registers done");
    wrt(8'h02, 8'h01);
    wrt(8'h00, 8'h03);
    repeat (3) @(posedge clk);
    rdc(8'h0a, 8'h0e);
    wrt(8'h02, 8'h00);
    rdc(8'h0a, 8'h06);
    repeat (800) @(posedge clk);
    chk("srst", 8'(sr_n), 8'h01);
    chk("software_freq_select", 8'(software_freq_select), 8'h03);
    wrt(8'h02, 8'h02);
    wrt(8'h00, 8'h07);
    wt(1, 1'b0);
    chk("expiry", 8'(n > 610 && n < 670), 8'h01);
    rdc(8'h02, 8'h82);
    wt(1, 1'b1);
    chk("width", 8'(n > 22800 && n < 23000), 8'h01);
    wrt(8'h02, 8'h80);
    rdc(8'h02, 8'h00);
    $display("watchdog done");
    @(posedge clk);
    pd_n <= 1'b0;
    wt(0, 1'b0);
    chk("cpu", 8'({t_o, toe, bst, coe}), 8'h0e);
    chk("aux", 8'({ro, ao}), 8'h00);
    wrt(8'h00, 8'h0f);
    rdc(8'h00, 8'h00);
    @(posedge clk);
    pd_n <= 1'b1;
    wt(0, 1'b1);
    while (ro !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk("wake", 8'(n < 300), 8'h01);
    rdc(8'h00, 8'h07);
    @(posedge clk);
    fam <= 1'b0;
    repeat (10) @(posedge clk);
    pd_n <= 1'b0;
    wt(0, 1'b0);
    chk("od", 8'({t_o, toe, c_o, coe}), 8'h05);
    @(posedge clk);
    pd_n <= 1'b1;
    wt(0, 1'b1);
    @(posedge clk);
    tpg_n <= 1'b1;
    repeat (20) @(posedge clk);
    rdc(8'h0a, 8'h04);
    $display("power-down done");
    close_out();
  end
endmodule
bind cwpd_ctrl cwpd_ctrl_asserts cwpd_ctrl_asserts_i (.*);
`default_nettype wire
